// [inc/sbl_pkg.sv]
// sbl_pkg: shared constants and carrier types of the serial boot loader.
// assumes a 250 MHz system clock and external UART controllers that take a divisor.
package sbl_pkg;
	// system clock and link timing
	localparam int unsigned CLK_HZ        = 250_000_000;                // system clock rate
	localparam int unsigned LINK_BAUD     = 19_200;                     // loader link speed
	localparam int unsigned OVERSAMPLE    = 16;                         // uart sampling ratio
	localparam int unsigned XTAL_A_HZ_X1K = 32_768;                     // 32.768 kHz crystal, in Hz
	localparam int unsigned XTAL_B_HZ_X1K = 38_400;                     // 38.4 kHz crystal, in Hz
	// divisor for the 32.768 kHz reference, and scaled for the faster crystal
	localparam logic [15:0] BAUD_DIV_A = 16'(CLK_HZ / (OVERSAMPLE * LINK_BAUD));
	localparam logic [15:0] BAUD_DIV_B = 16'((CLK_HZ / (OVERSAMPLE * LINK_BAUD)) * XTAL_A_HZ_X1K / XTAL_B_HZ_X1K);
	// character framing: no parity, eight data bits, one stop bit
	localparam logic        FRAME_PARITY = 1'h0;
	localparam logic [3:0]  FRAME_DATA   = 4'h8;
	localparam logic [1:0]  FRAME_STOP   = 2'h1;
	// characters
	localparam logic [7:0]  CHAR_ACK   = 8'h40;                         // link acknowledge
	localparam logic [7:0]  CHAR_CR    = 8'h0D;                         // record terminator
	localparam logic [7:0]  CHAR_0     = 8'h30;
	localparam logic [7:0]  CHAR_9     = 8'h39;
	localparam logic [7:0]  CHAR_A     = 8'h41;
	localparam logic [7:0]  CHAR_F     = 8'h46;
	localparam logic [7:0]  CHAR_ALPHA = 8'h37;                         // 'A' minus ten
	// record field layout, in hex digits
	localparam logic [9:0]  ADDR_DIGITS  = 10'h008;
	localparam logic [9:0]  HEAD_DIGITS  = 10'h00A;
	// instruction buffer
	localparam logic [31:0] IBUF_BASE  = 32'h00FF_FFC0;
	localparam int unsigned IBUF_BYTES = 32;
	localparam logic [15:0] NOP_OPCODE = 16'h4E71;                      // host pads the buffer
	// internally supplied reset vectors (stack pointer, program counter)
	localparam logic [31:0] VEC_SP = 32'h0000_1000;
	localparam logic [31:0] VEC_PC = 32'h00FF_FE00;
	// staging buffer
	localparam int unsigned STAGE_DEPTH = 32;
	// operating modes, lowest priority first; decode checks them in reverse order
	typedef enum logic [1:0] {SBL_MODE_NORMAL, SBL_MODE_EMUL, SBL_MODE_LOADER} sbl_mode_t;
	// one byte store toward memory or a register
	typedef struct packed {
		logic [31:0] addr;
		logic [7:0]  data;
	} sbl_wr_t;
	// uart controller settings
	typedef struct packed {
		logic [15:0] baud_div;
		logic        parity_en;
		logic [3:0]  data_bits;
		logic [1:0]  stop_bits;
	} sbl_uart_cfg_t;
endpackage : sbl_pkg

// [hw/sbl_loader.sv]
// sbl_loader: boot-time serial loader with its staging fifo.
// assumes two uart controllers with byte handshakes, a cpu vector fetch port and a byte write port.
// Functional notes
// R01: both uarts at 19200, 8N1; host likewise
// R02: first character picks crystal, adjusts divisor
// R03: first port with data becomes loader port
// R04: first character discarded, never stored
// R05: host holds break pin low through reset
// R06: loader mode beats emulation and normal
// R07: supply internal reset vectors, then run loader
// R08: accept uppercase records ended by carriage return
// R09: records accepted only through the uart
// R10: store count data bytes from address field
// R11: registers written exactly like memory
// R12: zero-count record starts execution at address
// R13: execution in ram hands over control
// R14: 32-byte instruction buffer at 0xFFFFC0
// R15: buffer run executes then returns to loader
// R16: send acknowledge, then echo first character
// R17: echo every received character
// R18: hex after non-hex starts new record
// R19: hex fields, address, count, data, msd first
`timescale 1ns/1ns
`default_nettype none

// fifo between the record parser and the write port
module sbl_fifo #(
	parameter int unsigned WIDTH = 40,
	parameter int unsigned DEPTH = 32
) (
	// clock and reset
	input  wire logic             clock_in,
	input  wire logic             reset_n_in,
	// fill side
	input  wire logic             in_valid_in,
	output logic                  in_ready_out,
	input  wire logic [WIDTH-1:0] in_data_in,
	// drain side
	output logic                  out_valid_out,
	input  wire logic             out_ready_in,
	output logic      [WIDTH-1:0] out_data_out
);
	localparam int unsigned AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];  // storage
	logic [AW-1:0]    wr_ptr;       // next slot to fill
	logic [AW-1:0]    rd_ptr;       // oldest slot
	logic [AW:0]      used;         // occupancy
	logic             push;
	logic             pop;

	assign in_ready_out  = (used != (AW+1)'(DEPTH));
	assign out_valid_out = (used != '0);
	assign out_data_out  = mem[rd_ptr];
	assign push          = in_valid_in & in_ready_out;
	assign pop           = out_valid_out & out_ready_in;

	// storage write, no reset needed on data
	always_ff @(posedge clock_in) begin
		if (push) begin
			mem[wr_ptr] <= in_data_in;
		end
	end

	// pointers and count
	always_ff @(posedge clock_in) begin
		if (!reset_n_in) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			used   <= '0;
		end else begin
			if (push) begin
				wr_ptr <= AW'(wr_ptr + 1'b1);
			end
			if (pop) begin
				rd_ptr <= AW'(rd_ptr + 1'b1);
			end
			used <= (AW+1)'(used + push - pop);
		end
	end
endmodule : sbl_fifo

module sbl_loader
	import sbl_pkg::*;
(
	// clock and reset
	input  wire logic          clock_in,
	input  wire logic          reset_n_in,
	// mode selection
	input  wire logic          break_select_pin_in,  // low through reset selects the loader
	input  wire logic          emul_request_in,      // emulation condition present
	output sbl_mode_t          mode_out,
	// cpu reset vector fetch
	input  wire logic [1:0]    vec_word_in,          // 0 sp hi, 1 sp lo, 2 pc hi, 3 pc lo
	output logic      [15:0]   vec_data_out,
	// uart settings and port choice
	output sbl_uart_cfg_t      uart1_cfg_out,
	output sbl_uart_cfg_t      uart2_cfg_out,
	output logic               port_locked_out,
	output logic               port_sel_out,         // 0 uart 1, 1 uart 2
	// uart receive
	input  wire logic          rx1_valid_in,
	input  wire logic [7:0]    rx1_data_in,
	output logic               rx1_ready_out,
	input  wire logic          rx2_valid_in,
	input  wire logic [7:0]    rx2_data_in,
	output logic               rx2_ready_out,
	// uart transmit, to the selected port
	output logic               tx1_valid_out,
	output logic               tx2_valid_out,
	input  wire logic          tx1_ready_in,
	input  wire logic          tx2_ready_in,
	output logic      [7:0]    tx_data_out,
	// byte write port toward memory and registers
	output logic               wr_valid_out,
	input  wire logic          wr_ready_in,
	output sbl_wr_t            wr_out,
	// instruction buffer fetch and run
	input  wire logic [4:0]    ibuf_addr_in,
	output logic      [7:0]    ibuf_data_out,
	output logic               ibuf_run_out,         // pulse: run buffer
	input  wire logic          ibuf_done_in,         // pulse: back to loader
	// hand-over to a downloaded program
	output logic               jump_out,             // pulse
	output logic      [31:0]   jump_addr_out
);
	typedef enum logic [2:0] {SBL_ST_FIRST, SBL_ST_ACK, SBL_ST_ECHO1, SBL_ST_RECV, SBL_ST_ECHO,
		SBL_ST_DRAIN, SBL_ST_RUN, SBL_ST_DONE} sbl_state_t;

	// hex digit test: uppercase only, lowercase counts as text
	function automatic logic sbl_is_hex(input logic [7:0] c);
		return ((c >= CHAR_0) && (c <= CHAR_9)) || ((c >= CHAR_A) && (c <= CHAR_F));
	endfunction : sbl_is_hex

	// hex digit value
	function automatic logic [3:0] sbl_nib(input logic [7:0] c);
		return (c <= CHAR_9) ? 4'(c - CHAR_0) : 4'(c - CHAR_ALPHA);
	endfunction : sbl_nib

	sbl_state_t  state;         // loader sequence
	logic        loader_mode;   // strap caught at reset
	logic        xtal_fast;     // 38.4 kHz reference detected
	logic [7:0]  first_char;    // kept only for the echo
	logic [7:0]  echo_char;     // character awaiting echo
	logic [31:0] rec_addr;      // address field
	logic [7:0]  rec_count;     // count field
	logic [7:0]  hi_nib;        // upper half of a data byte
	logic [9:0]  ndig;          // digits in this record
	logic        prev_hex;      // last character was a digit
	logic        exec_pend;     // execution record waiting for drain
	logic [7:0]  ibuf [IBUF_BYTES];
	logic        rx_valid;
	logic [7:0]  rx_data;
	logic        rx_take;
	logic        is_hex;
	logic [3:0]  nib;
	logic [9:0]  next_ndig;
	logic [7:0]  byte_idx;
	logic        push;
	sbl_wr_t     push_wr;
	logic        stage_ready;
	logic        stage_valid;
	sbl_wr_t     stage_wr;
	logic        to_ibuf;
	logic        tx_ready;
	logic        tx_valid;

	// mode strap sampled while reset is held; loader wins every tie
	always_ff @(posedge clock_in) begin
		if (!reset_n_in) begin
			loader_mode <= ~break_select_pin_in;  // [R05]
		end
	end
	always_comb begin
		if (loader_mode) begin
			mode_out = SBL_MODE_LOADER;  // [R06]
		end else if (emul_request_in) begin
			mode_out = SBL_MODE_EMUL;
		end else begin
			mode_out = SBL_MODE_NORMAL;
		end
	end

	// reset vectors from constants so no memory is needed to boot
	always_ff @(posedge clock_in) begin
		if (!reset_n_in) begin
			vec_data_out <= 16'h0000;
		end else begin
			case (vec_word_in)  // [R07]
				2'h0: vec_data_out <= VEC_SP[31:16];
				2'h1: vec_data_out <= VEC_SP[15:0];
				2'h2: vec_data_out <= VEC_PC[31:16];
				default: vec_data_out <= VEC_PC[15:0];
			endcase
		end
	end

	// both controllers carry the same framing; divisor follows the crystal
	always_comb begin
		uart1_cfg_out.baud_div  = xtal_fast ? BAUD_DIV_B : BAUD_DIV_A;  // [R01] [R02]
		uart1_cfg_out.parity_en = FRAME_PARITY;
		uart1_cfg_out.data_bits = FRAME_DATA;
		uart1_cfg_out.stop_bits = FRAME_STOP;
		uart2_cfg_out           = uart1_cfg_out;
	end

	// receive side: before lock either port, afterwards only the chosen one
	assign rx_valid = port_locked_out ? (port_sel_out ? rx2_valid_in : rx1_valid_in)
	                                  : (rx1_valid_in | rx2_valid_in);
	assign rx_data  = (port_locked_out ? port_sel_out : ~rx1_valid_in) ? rx2_data_in : rx1_data_in;
	// a character is taken only when its echo and any byte store have room
	assign rx_take  = rx_valid & ((state == SBL_ST_FIRST) | ((state == SBL_ST_RECV) & stage_ready));  // [R09]
	assign rx1_ready_out = rx_take & (port_locked_out ? ~port_sel_out : rx1_valid_in);
	assign rx2_ready_out = rx_take & (port_locked_out ? port_sel_out : ~rx1_valid_in);

	// transmit side
	assign tx_ready      = port_sel_out ? tx2_ready_in : tx1_ready_in;
	assign tx_valid      = (state == SBL_ST_ACK) | (state == SBL_ST_ECHO1) | (state == SBL_ST_ECHO);
	assign tx1_valid_out = tx_valid & ~port_sel_out;
	assign tx2_valid_out = tx_valid & port_sel_out;
	always_comb begin
		case (state)
			SBL_ST_ACK:   tx_data_out = CHAR_ACK;    // [R16]
			SBL_ST_ECHO1: tx_data_out = first_char;  // [R16]
			default:      tx_data_out = echo_char;   // [R17]
		endcase
	end

	// port and crystal decided once, by the first character
	always_ff @(posedge clock_in) begin
		if (!reset_n_in) begin
			port_locked_out <= 1'b0;
			port_sel_out    <= 1'b0;
			xtal_fast       <= 1'b0;
			first_char      <= 8'h00;
		end else if (rx_take && (state == SBL_ST_FIRST)) begin
			port_locked_out <= 1'b1;
			port_sel_out    <= ~rx1_valid_in;  // [R03] uart 1 wins a tie
			xtal_fast       <= rx_data[7];     // [R02] fast crystal garbles the top bit
			first_char      <= rx_data;        // [R04] echoed only, never parsed
		end
	end

	// record parser, combinational part
	assign is_hex   = sbl_is_hex(rx_data);  // [R08]
	assign nib      = sbl_nib(rx_data);
	assign next_ndig = prev_hex ? 10'(ndig + 1'b1) : 10'h001;  // [R18]
	assign byte_idx = 8'((next_ndig - HEAD_DIGITS - 1'b1) >> 1);
	assign push     = rx_take && (state == SBL_ST_RECV) && is_hex && (next_ndig > HEAD_DIGITS)
	                  && !next_ndig[0] && (byte_idx < rec_count);  // [R10]
	assign push_wr.addr = 32'(rec_addr + byte_idx);
	assign push_wr.data = {hi_nib[3:0], nib};

	// record parser fields, most significant digit first
	always_ff @(posedge clock_in) begin
		if (!reset_n_in) begin
			rec_addr  <= 32'h0000_0000;
			rec_count <= 8'h00;
			hi_nib    <= 8'h00;
			ndig      <= 10'h000;
			prev_hex  <= 1'b0;
		end else if (rx_take && (state == SBL_ST_RECV)) begin
			prev_hex <= is_hex;
			if (is_hex) begin
				ndig <= next_ndig;
				if (next_ndig <= ADDR_DIGITS) begin
					rec_addr <= prev_hex ? {rec_addr[27:0], nib} : {28'h0, nib};  // [R19]
				end else if (next_ndig <= HEAD_DIGITS) begin
					rec_count <= {rec_count[3:0], nib};  // [R19]
				end else begin
					hi_nib <= {4'h0, nib};
				end
			end
		end
	end

	// sequence; execution waits until every staged byte has landed
	always_ff @(posedge clock_in) begin
		if (!reset_n_in) begin
			state     <= SBL_ST_FIRST;
			echo_char <= 8'h00;
			exec_pend <= 1'b0;
		end else begin
			case (state)
				SBL_ST_FIRST: begin
					if (rx_take) begin
						state <= SBL_ST_ACK;
					end
				end
				SBL_ST_ACK: begin
					if (tx_ready) begin
						state <= SBL_ST_ECHO1;
					end
				end
				SBL_ST_ECHO1: begin
					if (tx_ready) begin
						state <= SBL_ST_RECV;
					end
				end
				SBL_ST_RECV: begin
					if (rx_take) begin
						echo_char <= rx_data;
						state     <= SBL_ST_ECHO;
						// zero count, no data, then carriage return
						exec_pend <= (rx_data == CHAR_CR) && prev_hex && (ndig == HEAD_DIGITS)
						             && (rec_count == 8'h00);  // [R08] [R12]
					end
				end
				SBL_ST_ECHO: begin
					if (tx_ready) begin
						state <= exec_pend ? SBL_ST_DRAIN : SBL_ST_RECV;
					end
				end
				SBL_ST_DRAIN: begin
					exec_pend <= 1'b0;
					if (!stage_valid) begin
						state <= (rec_addr == IBUF_BASE) ? SBL_ST_RUN : SBL_ST_DONE;  // [R13] [R15]
					end
				end
				SBL_ST_RUN: begin
					if (ibuf_done_in) begin
						state <= SBL_ST_RECV;  // [R15]
					end
				end
				default: begin
					state <= SBL_ST_DONE;  // control has left the loader
				end
			endcase
		end
	end

	// one-cycle start pulses, data from flops
	always_ff @(posedge clock_in) begin
		if (!reset_n_in) begin
			ibuf_run_out  <= 1'b0;
			jump_out      <= 1'b0;
			jump_addr_out <= 32'h0000_0000;
		end else begin
			ibuf_run_out <= (state == SBL_ST_DRAIN) && !stage_valid && (rec_addr == IBUF_BASE);
			jump_out     <= (state == SBL_ST_DRAIN) && !stage_valid && (rec_addr != IBUF_BASE);  // [R13]
			if ((state == SBL_ST_DRAIN) && !stage_valid) begin
				jump_addr_out <= rec_addr;  // [R12]
			end
		end
	end

	// staging fifo between parser and write port; a full fifo stalls receive
	sbl_fifo #(
		.WIDTH ($bits(sbl_wr_t)),
		.DEPTH (STAGE_DEPTH)
	) u_stage (
		.clock_in      (clock_in),
		.reset_n_in    (reset_n_in),
		.in_valid_in   (push),
		.in_ready_out  (stage_ready),
		.in_data_in    (push_wr),
		.out_valid_out (stage_valid),
		.out_ready_in  (to_ibuf | wr_ready_in),
		.out_data_out  (stage_wr)
	);

	// buffer range is local; everything else, registers included, goes out
	assign to_ibuf      = (stage_wr.addr[31:5] == IBUF_BASE[31:5]);  // [R14]
	assign wr_valid_out = stage_valid & ~to_ibuf;                    // [R11]
	assign wr_out       = stage_wr;

	// instruction buffer storage and cpu fetch
	always_ff @(posedge clock_in) begin
		if (stage_valid && to_ibuf) begin
			ibuf[stage_wr.addr[4:0]] <= stage_wr.data;  // [R14]
		end
	end
	always_ff @(posedge clock_in) begin
		if (!reset_n_in) begin
			ibuf_data_out <= 8'h00;
		end else begin
			ibuf_data_out <= ibuf[ibuf_addr_in];
		end
	end

	// checks
	sequence s_first_taken;
		rx_take && (state == SBL_ST_FIRST);
	endsequence
	sequence s_ack_sent;
		tx_valid && tx_ready && (tx_data_out == CHAR_ACK);
	endsequence

	a_mode_priority: assert property (@(posedge clock_in) disable iff (!reset_n_in)  // [R06]
		loader_mode |-> (mode_out == SBL_MODE_LOADER)) else $error("loader mode lost priority");
	a_ack_after_first: assert property (@(posedge clock_in) disable iff (!reset_n_in)  // [R16]
		s_first_taken |=> (state == SBL_ST_ACK) && tx_valid && (tx_data_out == CHAR_ACK))
		else $error("no acknowledge after first character");
	a_first_echo: assert property (@(posedge clock_in) disable iff (!reset_n_in)  // [R16]
		s_ack_sent |=> tx_valid && (tx_data_out == first_char)) else $error("first character not echoed");
	a_port_stable: assert property (@(posedge clock_in) disable iff (!reset_n_in)  // [R03]
		$past(port_locked_out) |-> $stable(port_sel_out)) else $error("loader port changed");
	a_first_no_store: assert property (@(posedge clock_in) disable iff (!reset_n_in)  // [R04]
		s_first_taken |-> !push) else $error("first character stored");
	a_echo_each: assert property (@(posedge clock_in) disable iff (!reset_n_in)  // [R17]
		(rx_take && (state == SBL_ST_RECV)) |=> tx_valid && (tx_data_out == $past(rx_data)))
		else $error("character not echoed");
	a_frame_fixed: assert property (@(posedge clock_in) disable iff (!reset_n_in)  // [R01]
		(uart1_cfg_out.data_bits == 4'h8) && !uart2_cfg_out.parity_en && (uart2_cfg_out.stop_bits == 2'h1)
		&& (uart1_cfg_out.baud_div == uart2_cfg_out.baud_div)) else $error("uart framing wrong");
	a_divisor_xtal: assert property (@(posedge clock_in) disable iff (!reset_n_in)  // [R02]
		s_first_taken |=> (uart1_cfg_out.baud_div == ($past(rx_data[7]) ? BAUD_DIV_B : BAUD_DIV_A)))
		else $error("divisor does not follow crystal");
	a_no_lower_hex: assert property (@(posedge clock_in) disable iff (!reset_n_in)  // [R08]
		(rx_take && (rx_data >= 8'h61) && (rx_data <= 8'h66)) |-> !push) else $error("lowercase digit stored");
	a_ibuf_local: assert property (@(posedge clock_in) disable iff (!reset_n_in)  // [R14]
		(stage_valid && (stage_wr.addr[31:5] == IBUF_BASE[31:5])) |-> !wr_valid_out)
		else $error("buffer byte leaked to write port");
	a_exec_drained: assert property (@(posedge clock_in) disable iff (!reset_n_in)  // [R13]
		$rose(jump_out) |-> ($past(state) == SBL_ST_DRAIN) && !$past(stage_valid))
		else $error("jump before bytes landed");
endmodule : sbl_loader
`default_nettype wire

// [tb/sbl_host_model.sv]
// sbl_host_model: host terminal on the far side of both loader uart byte ports.
// assumes the loader's valid/ready byte handshakes; tb calls send() and reads echo_q.
`timescale 1ns/1ns
`default_nettype none

module sbl_host_model (
	// clock and reset
	input  wire logic       clock_in,
	input  wire logic       reset_n_in,
	// characters toward the loader
	output logic            rx1_valid_out,
	output logic [7:0]      rx1_data_out,
	input  wire logic       rx1_ready_in,
	output logic            rx2_valid_out,
	output logic [7:0]      rx2_data_out,
	input  wire logic       rx2_ready_in,
	// echoes from the loader
	input  wire logic       tx1_valid_in,
	input  wire logic       tx2_valid_in,
	input  wire logic [7:0] tx_data_in,
	output logic            tx1_ready_out,
	output logic            tx2_ready_out
);
	logic       ready_r;      // one-cycle accept strobe
	int         slow;         // extra stall cycles before accepting
	int         wait_n;       // stall counter
	logic [8:0] echo_q[$];    // {port, char} as received

	initial begin
		ready_r       = 1'h0;
		slow          = 0;
		wait_n        = 0;
		rx1_valid_out = 1'h0;
		rx2_valid_out = 1'h0;
		rx1_data_out  = 8'hA5;
		rx2_data_out  = 8'h5A;
	end
	assign tx1_ready_out = ready_r;
	assign tx2_ready_out = ready_r;

	// accept echoes, optionally late, so the loader must hold its byte
	always @(posedge clock_in) begin
		if ((tx1_valid_in | tx2_valid_in) && ready_r)
			echo_q.push_back({tx2_valid_in, tx_data_in});
		ready_r <= 1'h0;
		if ((tx1_valid_in | tx2_valid_in) && !ready_r && reset_n_in) begin
			if (wait_n >= slow) begin
				ready_r <= 1'h1;
				wait_n = 0;
			end else
				wait_n++;
		end
	end

	// offer one character, hold it until taken or refused; ascii 8n1 bytes
	task automatic send(input bit port, input logic [7:0] ch, output bit ok);
		int n;
		@(posedge clock_in);
		if (port) begin
			rx2_valid_out <= 1'h1;
			rx2_data_out  <= ch;
		end else begin
			rx1_valid_out <= 1'h1;
			rx1_data_out  <= ch;
		end
		ok = 1'b0;
		for (n = 0; n < 40 && !ok; n++) begin
			@(posedge clock_in);
			ok = port ? rx2_ready_in : rx1_ready_in;
		end
		// released line shows the inverse, never the stale byte
		rx1_valid_out <= 1'h0;
		rx2_valid_out <= 1'h0;
		rx1_data_out  <= ~ch;
		rx2_data_out  <= ~ch;
	endtask : send
endmodule : sbl_host_model

`default_nettype wire

// [tb/sbl_loader_test.sv]
// sbl_loader_test: self-checking bench of the serial loader.
// assumes sbl_host_model as the terminal and a write sink that stalls every other cycle.
`timescale 1ns/1ns
`default_nettype none

module sbl_loader_test;
	import sbl_pkg::*;
	logic clock_in = 1'h0, reset_n_in = 1'h0, break_select_pin_in = 1'h0, emul_request_in = 1'h1;
	logic wr_ready_in = 1'h0, ibuf_done_in = 1'h0;
	logic [1:0] vec_word_in = 2'h0;
	logic [4:0] ibuf_addr_in = 5'h00;
	sbl_mode_t mode_out;
	sbl_uart_cfg_t uart1_cfg_out, uart2_cfg_out;
	logic [15:0] vec_data_out;
	logic port_locked_out, port_sel_out, rx1_valid_in, rx2_valid_in, rx1_ready_out, rx2_ready_out;
	logic [7:0] rx1_data_in, rx2_data_in, tx_data_out, ibuf_data_out;
	logic tx1_valid_out, tx2_valid_out, tx1_ready_in, tx2_ready_in, wr_valid_out, ibuf_run_out, jump_out;
	sbl_wr_t wr_out;
	logic [31:0] jump_addr_out;
	sbl_wr_t wq[$];          // stores seen on the write port
	int runs = 0, jumps = 0, cycles = 0, num_errors = 0, checked = 0;

	always #2 clock_in = ~clock_in;

	sbl_loader u_dut (.clock_in(clock_in), .reset_n_in(reset_n_in), .break_select_pin_in(break_select_pin_in),
		.emul_request_in(emul_request_in), .mode_out(mode_out), .vec_word_in(vec_word_in),
		.vec_data_out(vec_data_out), .uart1_cfg_out(uart1_cfg_out), .uart2_cfg_out(uart2_cfg_out),
		.port_locked_out(port_locked_out), .port_sel_out(port_sel_out), .rx1_valid_in(rx1_valid_in),
		.rx1_data_in(rx1_data_in), .rx1_ready_out(rx1_ready_out), .rx2_valid_in(rx2_valid_in),
		.rx2_data_in(rx2_data_in), .rx2_ready_out(rx2_ready_out), .tx1_valid_out(tx1_valid_out),
		.tx2_valid_out(tx2_valid_out), .tx1_ready_in(tx1_ready_in), .tx2_ready_in(tx2_ready_in),
		.tx_data_out(tx_data_out), .wr_valid_out(wr_valid_out), .wr_ready_in(wr_ready_in), .wr_out(wr_out),
		.ibuf_addr_in(ibuf_addr_in), .ibuf_data_out(ibuf_data_out), .ibuf_run_out(ibuf_run_out),
		.ibuf_done_in(ibuf_done_in), .jump_out(jump_out), .jump_addr_out(jump_addr_out));

	sbl_host_model u_host (.clock_in(clock_in), .reset_n_in(reset_n_in), .rx1_valid_out(rx1_valid_in),
		.rx1_data_out(rx1_data_in), .rx1_ready_in(rx1_ready_out), .rx2_valid_out(rx2_valid_in),
		.rx2_data_out(rx2_data_in), .rx2_ready_in(rx2_ready_out), .tx1_valid_in(tx1_valid_out),
		.tx2_valid_in(tx2_valid_out), .tx_data_in(tx_data_out), .tx1_ready_out(tx1_ready_in),
		.tx2_ready_out(tx2_ready_in));

	// write sink stalls on alternate cycles; pulses counted; hang guard
	always @(posedge clock_in) begin
		if (wr_valid_out === 1'b1 && wr_ready_in)
			wq.push_back(wr_out);
		wr_ready_in <= ~wr_ready_in;
		if (ibuf_run_out === 1'b1)
			runs++;
		if (jump_out === 1'b1)
			jumps++;
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			report_and_stop();
		end
	end

	task automatic chk(input string what, input logic [39:0] exp, input logic [39:0] got);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : report_and_stop

	// reset with the break strap low, emulation also requested
	task automatic do_reset();
		reset_n_in          <= 1'h0;
		break_select_pin_in <= 1'h0;
		repeat (5) @(posedge clock_in);
		@(negedge clock_in);
		chk("mode", 40'(SBL_MODE_LOADER), 40'(mode_out));
		@(posedge clock_in);
		reset_n_in          <= 1'h1;
		break_select_pin_in <= 1'h1;
	endtask : do_reset

	task automatic get_echo(output logic [8:0] e);
		int n;
		for (n = 0; n < 80 && u_host.echo_q.size() == 0; n++)
			@(posedge clock_in);
		e = (u_host.echo_q.size() > 0) ? u_host.echo_q.pop_front() : 9'bx;
	endtask : get_echo

	// send each character and demand its echo on the same port
	task automatic send_str(input string s, input bit port);
		bit ok;
		logic [8:0] e;
		for (int i = 0; i < s.len(); i++) begin
			u_host.send(port, s[i], ok);
			get_echo(e);
			chk("echo", {port, s[i]}, e);
		end
	endtask : send_str

	// first character opens the link: ack, echo, crystal and port chosen
	task automatic t_first(input bit port, input logic [7:0] ch, input logic [15:0] div);
		bit ok;
		logic [8:0] e;
		u_host.send(port, ch, ok);
		get_echo(e);
		chk("ack", {port, CHAR_ACK}, e);
		get_echo(e);
		chk("first echo", {port, ch}, e);
		@(negedge clock_in);
		chk("port", {port, 1'b1}, {port_sel_out, port_locked_out});
		chk("cfg1", 40'({div, FRAME_PARITY, FRAME_DATA, FRAME_STOP}), 40'(uart1_cfg_out));
		chk("cfg2", 40'({div, FRAME_PARITY, FRAME_DATA, FRAME_STOP}), 40'(uart2_cfg_out));
		u_host.send(!port, 8'h30, ok);
		chk("other port", 40'h0, 40'(ok));
		$display("test first char port %0d done", port);
	endtask : t_first

	task automatic t_vectors();
		logic [15:0] exp [4];
		exp = '{VEC_SP[31:16], VEC_SP[15:0], VEC_PC[31:16], VEC_PC[15:0]};
		for (int w = 0; w < 4; w++) begin
			@(posedge clock_in);
			vec_word_in <= 2'(w);
			@(posedge clock_in);
			@(negedge clock_in);
			chk("vector", 40'(exp[w]), 40'(vec_data_out));
		end
		$display("test vectors done");
	endtask : t_vectors

	// comment, data record and register record with slow host and stalling sink
	task automatic t_data();
		u_host.slow = 3;
		send_str("* INIT face\015", 1'b1);
		send_str("00001000021F2A\015", 1'b1);
		send_str("FFFFF43B01CF\015", 1'b1);
		u_host.slow = 0;
		for (int n = 0; n < 100 && wq.size() < 3; n++)
			@(posedge clock_in);
		chk("store count", 40'h3, 40'(wq.size()));
		chk("store 0", {32'h0000_1000, 8'h1F}, (wq.size() > 0) ? wq[0] : 40'bx);
		chk("store 1", {32'h0000_1001, 8'h2A}, (wq.size() > 1) ? wq[1] : 40'bx);
		chk("store reg", {32'hFFFF_F43B, 8'hCF}, (wq.size() > 2) ? wq[2] : 40'bx);
		$display("test data records done");
	endtask : t_data

	// load the instruction buffer, run it, come back to the loader
	task automatic t_ibuf();
		send_str("00FFFFC0024E71\015", 1'b1);
		send_str("00FFFFC000\015", 1'b1);
		for (int n = 0; n < 100 && runs == 0; n++)
			@(posedge clock_in);
		chk("buffer run", 40'h1, 40'(runs));
		for (int a = 0; a < 2; a++) begin
			ibuf_addr_in <= 5'(a);
			@(posedge clock_in);
			@(posedge clock_in);
			@(negedge clock_in);
			chk("buffer byte", (a == 0) ? 40'h4E : 40'h71, 40'(ibuf_data_out));
		end
		@(posedge clock_in);
		ibuf_done_in <= 1'h1;
		@(posedge clock_in);
		ibuf_done_in <= 1'h0;
		send_str("*", 1'b1);
		chk("no port store", 40'h3, 40'(wq.size()));
		$display("test instruction buffer done");
	endtask : t_ibuf

	// execution record hands control to a program, loader then stops
	task automatic t_jump();
		bit ok;
		send_str("0000100000\015", 1'b1);
		for (int n = 0; n < 100 && jumps == 0; n++)
			@(posedge clock_in);
		chk("jump", {8'h01, 32'h0000_1000}, {8'(jumps), jump_addr_out});
		u_host.send(1'b1, 8'h2A, ok);
		chk("after jump", 40'h0, 40'(ok));
		$display("test jump done");
	endtask : t_jump

	// strap high through reset: loader off, emulation request then decides the mode
	task automatic t_modes();
		reset_n_in          <= 1'h0;
		break_select_pin_in <= 1'h1;
		repeat (5) @(posedge clock_in);
		@(negedge clock_in);
		chk("mode emul", 40'(SBL_MODE_EMUL), 40'(mode_out));
		@(posedge clock_in);
		emul_request_in <= 1'h0;
		@(negedge clock_in);
		chk("mode normal", 40'(SBL_MODE_NORMAL), 40'(mode_out));
		$display("test modes done");
	endtask : t_modes

	initial begin
		do_reset();
		t_vectors();
		t_first(1'b0, 8'h85, BAUD_DIV_B);
		do_reset();
		t_first(1'b1, 8'h12, BAUD_DIV_A);
		t_data();
		t_ibuf();
		t_jump();
		t_modes();
		report_and_stop();
	end
endmodule : sbl_loader_test

`default_nettype wire
